// [core/osl_pkg.sv]
// Package of constants and types for the output signal logic combiner
package osl_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_COMB = 6;
    localparam int NUM_TERM = 5;
    localparam int SIG_W = 6;
    localparam int NUM_SIG = 64;

    // ------------------------------------------------------------
    // Output-signal codes
    // ------------------------------------------------------------
    localparam logic [5:0] CODE_MAX = 6'h38;        // 56
    localparam logic [5:0] CODE_START = 6'h0b;      // 11, terminal
    localparam logic [5:0] CODE_START_RLY = 6'h29;  // 41, relay
    localparam logic [5:0] CODE_LINK_TO = 6'h20;    // 32
    localparam logic [5:0] CODE_COMB_FIRST = 6'h21; // 33
    localparam logic [5:0] CODE_COMB_LAST = 6'h26;  // 38
    localparam logic [5:0] CODE_CAP_LIFE = 6'h27;   // 39
    localparam logic [5:0] CODE_FAN_DROP = 6'h28;   // 40

    // ------------------------------------------------------------
    // Operator and mode encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OSL_OP_AND = 2'h0,
        OSL_OP_OR = 2'h1,
        OSL_OP_XOR = 2'h2
    } osl_op_t;
    localparam logic [1:0] FAN_CTRL_NO_WARN = 2'h1;

    // ------------------------------------------------------------
    // Timing: timeout in 10 ms steps, 0.00 to 99.99 s
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;
    localparam logic [13:0] LIMIT_MAX = 14'h270f; // 9999 steps

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_COMB_BASE = 8'h00; // 0x00..0x05: a[5:0],b[13:8],op[17:16]
    localparam logic [7:0] ADDR_TERM_BASE = 8'h08; // 0x08..0x0c terminal codes
    localparam logic [7:0] ADDR_RELAY = 8'h0d;
    localparam logic [7:0] ADDR_CTRL = 8'h10;      // [0] modbus, [2:1] fan mode
    localparam logic [7:0] ADDR_LIMIT = 8'h11;     // [13:0] timeout limit
    localparam logic [7:0] ADDR_LIFE = 8'h12;      // [0] cap life, [1] fan drop
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h13;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_RESULT = 8'h15;    // [5:0] combiner results
    localparam logic [31:0] RST_ZERO = 32'h0;
    localparam logic [5:0] RST_TERM_CODE = 6'h3f;  // Unused code, output low

    // Interrupt status bits
    localparam int IRQ_CAP = 0;
    localparam int IRQ_FAN = 1;
    localparam int IRQ_LINK = 2;
    localparam int IRQ_BOTH_RUN = 3;
    localparam int IRQ_W = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } osl_bus_req_t;

    typedef struct packed {
        logic [1:0] op;
        logic [5:0] selB;
        logic [5:0] selA;
    } osl_comb_cfg_t;

endpackage : osl_pkg

// [core/osl_combiner.sv]
// Output signal logic combiner with status flags and register port
`timescale 1ns/1ps
module osl_combiner #(
    parameter int TICK_CYCLES = osl_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Register port
    input wire osl_pkg::osl_bus_req_t busReq,
    output logic [31:0] rdData,
    // Internal drive status signals indexed by output code
    input wire logic [63:0] statusSig,
    // Monitor and command inputs from other drive logic
    input wire logic capLifeDue,
    input wire logic fanBelowLimit,
    input wire logic linkRxData,
    input wire logic fwdRunCmd,
    input wire logic revRunCmd,
    // Outputs
    output logic [4:0] termOut,
    output logic relayOut,
    output logic motorStop,
    output logic irq
);

    // ------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------
    osl_pkg::osl_comb_cfg_t combCfg_r [osl_pkg::NUM_COMB];
    logic [5:0] termSel_r [osl_pkg::NUM_TERM];
    logic [5:0] relaySel_r;
    logic modbusSel_r;
    logic [1:0] fanMode_r;
    logic [13:0] limit_r;
    logic [osl_pkg::IRQ_W-1:0] irqStat_r;
    logic [osl_pkg::IRQ_W-1:0] irqMask_r;
    logic [osl_pkg::IRQ_W-1:0] irqEvt;

    // Status state
    logic capLife_r;
    logic fanDrop_r;
    logic linkTimeout_r;
    logic startContact_r;
    logic bothRun_r;
    logic [5:0] combRes;
    logic [63:0] sigVec;

    // Timeout counting
    logic [$clog2(TICK_CYCLES)-1:0] tickCnt_r;
    logic [13:0] stepCnt_r;
    logic tick;

    // Bus helpers
    logic [7:0] addr;
    logic wrEn;
    assign addr = busReq.addr;
    assign wrEn = busReq.wr & clkEn;

    // ------------------------------------------------------------
    // Combiner array and signal vector
    // ------------------------------------------------------------
    // Result codes are masked out before operand selection so no loop can form
    always_comb begin
        sigVec = statusSig;
        sigVec[osl_pkg::CODE_START] = startContact_r;
        sigVec[osl_pkg::CODE_START_RLY] = startContact_r;
        sigVec[osl_pkg::CODE_LINK_TO] = linkTimeout_r;
        sigVec[osl_pkg::CODE_CAP_LIFE] = capLife_r;
        sigVec[osl_pkg::CODE_FAN_DROP] = fanDrop_r;
        for (int i = 0; i < osl_pkg::NUM_COMB; i++) begin
            sigVec[int'(osl_pkg::CODE_COMB_FIRST) + i] = 1'b0;
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < osl_pkg::NUM_COMB; gc++) begin : g_comb
            logic opA;
            logic opB;
            // Codes above 56 read as zero; own settings per combiner
            assign opA = (combCfg_r[gc].selA <= osl_pkg::CODE_MAX) ?
                sigVec[combCfg_r[gc].selA] : 1'b0;
            assign opB = (combCfg_r[gc].selB <= osl_pkg::CODE_MAX) ?
                sigVec[combCfg_r[gc].selB] : 1'b0;
            // Pure combinational recompute every cycle
            always_comb begin
                unique case (combCfg_r[gc].op)
                    osl_pkg::OSL_OP_AND: combRes[gc] = opA & opB;
                    osl_pkg::OSL_OP_OR: combRes[gc] = opA | opB;
                    osl_pkg::OSL_OP_XOR: combRes[gc] = opA ^ opB;
                    default: combRes[gc] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Routing of a code to one output, results at 33..38
    function automatic logic routeSel(input logic [5:0] code, input logic [63:0] sv,
                                      input logic [5:0] res);
        logic [5:0] idx;
        idx = code - osl_pkg::CODE_COMB_FIRST;
        if (code >= osl_pkg::CODE_COMB_FIRST && code <= osl_pkg::CODE_COMB_LAST) begin
            routeSel = res[idx[2:0]];
        end else if (code <= osl_pkg::CODE_MAX) begin
            routeSel = sv[code];
        end else begin
            routeSel = 1'b0;
        end
    endfunction : routeSel

    // ------------------------------------------------------------
    // Output terminals and relay
    // ------------------------------------------------------------
    // Registered so every output comes from a flip-flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            termOut <= 5'h0;
            relayOut <= 1'b0;
        end else if (clkEn) begin
            for (int t = 0; t < osl_pkg::NUM_TERM; t++) begin
                termOut[t] <= routeSel(termSel_r[t], sigVec, combRes);
            end
            relayOut <= routeSel(relaySel_r, sigVec, combRes);
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Capacitor life and fan drop follow their monitors
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            capLife_r <= 1'b0;
            fanDrop_r <= 1'b0;
        end else if (clkEn) begin
            capLife_r <= capLifeDue;
            // Fan mode 01 blocks the warning even with a stopped fan
            fanDrop_r <= fanBelowLimit & (fanMode_r != osl_pkg::FAN_CTRL_NO_WARN);
        end
    end

    // Starting contact and the run-conflict stop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            startContact_r <= 1'b0;
            bothRun_r <= 1'b0;
            motorStop <= 1'b0;
        end else if (clkEn) begin
            // Whatever source delivers the command, presence alone counts
            startContact_r <= fwdRunCmd | revRunCmd;
            bothRun_r <= fwdRunCmd & revRunCmd;
            motorStop <= fwdRunCmd & revRunCmd;
        end
    end

    // ------------------------------------------------------------
    // Link reception timeout
    // ------------------------------------------------------------
    assign tick = (tickCnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

    // 10 ms prescaler, restarted by each received datum; frozen with the enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickCnt_r <= '0;
        end else if (clkEn) begin
            tickCnt_r <= (tick || linkRxData) ? '0 : tickCnt_r + 1'b1;
        end
    end

    // Step counter and held flag; limit zero disables the check
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stepCnt_r <= 14'h0;
            linkTimeout_r <= 1'b0;
        end else if (clkEn) begin
            if (!modbusSel_r) begin
                stepCnt_r <= 14'h0;
                linkTimeout_r <= 1'b0;
            end else if (linkRxData) begin
                stepCnt_r <= 14'h0;
                linkTimeout_r <= 1'b0;
            end else if (limit_r != 14'h0 && tick) begin
                if (stepCnt_r + 14'h1 >= limit_r) begin
                    linkTimeout_r <= 1'b1;
                end else begin
                    stepCnt_r <= stepCnt_r + 14'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < osl_pkg::NUM_COMB; i++) begin
                combCfg_r[i] <= '0;
            end
            for (int t = 0; t < osl_pkg::NUM_TERM; t++) begin
                termSel_r[t] <= osl_pkg::RST_TERM_CODE;
            end
            relaySel_r <= osl_pkg::RST_TERM_CODE;
            modbusSel_r <= 1'b0;
            fanMode_r <= 2'h0;
            limit_r <= 14'h0;
            irqMask_r <= '0;
        end else if (wrEn) begin
            for (int i = 0; i < osl_pkg::NUM_COMB; i++) begin
                if (addr == osl_pkg::ADDR_COMB_BASE + 8'(i)) begin
                    combCfg_r[i].selA <= busReq.wdata[5:0];
                    combCfg_r[i].selB <= busReq.wdata[13:8];
                    combCfg_r[i].op <= busReq.wdata[17:16];
                end
            end
            for (int t = 0; t < osl_pkg::NUM_TERM; t++) begin
                if (addr == osl_pkg::ADDR_TERM_BASE + 8'(t)) begin
                    termSel_r[t] <= busReq.wdata[5:0];
                end
            end
            if (addr == osl_pkg::ADDR_RELAY) begin
                relaySel_r <= busReq.wdata[5:0];
            end
            if (addr == osl_pkg::ADDR_CTRL) begin
                modbusSel_r <= busReq.wdata[0];
                fanMode_r <= busReq.wdata[2:1];
            end
            if (addr == osl_pkg::ADDR_LIMIT) begin
                // Values above 99.99 s saturate
                limit_r <= (busReq.wdata[13:0] > osl_pkg::LIMIT_MAX) ?
                    osl_pkg::LIMIT_MAX : busReq.wdata[13:0];
            end
            if (addr == osl_pkg::ADDR_IRQ_MASK) begin
                irqMask_r <= busReq.wdata[osl_pkg::IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Rising edges of the flags; a set in the clearing cycle wins
    always_comb begin
        irqEvt = '0;
        irqEvt[osl_pkg::IRQ_CAP] = capLifeDue & ~capLife_r;
        irqEvt[osl_pkg::IRQ_FAN] = fanBelowLimit & ~fanDrop_r &
            (fanMode_r != osl_pkg::FAN_CTRL_NO_WARN);
        irqEvt[osl_pkg::IRQ_LINK] = modbusSel_r & ~linkRxData & ~linkTimeout_r &
            (limit_r != 14'h0) & tick & (stepCnt_r + 14'h1 >= limit_r);
        irqEvt[osl_pkg::IRQ_BOTH_RUN] = fwdRunCmd & revRunCmd & ~bothRun_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStat_r <= '0;
            irq <= 1'b0;
        end else if (clkEn) begin
            if (wrEn && addr == osl_pkg::ADDR_IRQ_STAT) begin
                irqStat_r <= (irqStat_r & ~busReq.wdata[osl_pkg::IRQ_W-1:0]) | irqEvt;
            end else begin
                irqStat_r <= irqStat_r | irqEvt;
            end
            irq <= |(irqStat_r & irqMask_r);
        end
    end

    // ------------------------------------------------------------
    // Register reads, data valid one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData <= osl_pkg::RST_ZERO;
        end else if (clkEn) begin
            rdData <= osl_pkg::RST_ZERO;
            if (busReq.rd) begin
                for (int i = 0; i < osl_pkg::NUM_COMB; i++) begin
                    if (addr == osl_pkg::ADDR_COMB_BASE + 8'(i)) begin
                        rdData <= {14'h0, combCfg_r[i].op, 2'h0, combCfg_r[i].selB,
                                   2'h0, combCfg_r[i].selA};
                    end
                end
                for (int t = 0; t < osl_pkg::NUM_TERM; t++) begin
                    if (addr == osl_pkg::ADDR_TERM_BASE + 8'(t)) begin
                        rdData <= {26'h0, termSel_r[t]};
                    end
                end
                unique case (addr)
                    osl_pkg::ADDR_RELAY: rdData <= {26'h0, relaySel_r};
                    osl_pkg::ADDR_CTRL: rdData <= {29'h0, fanMode_r, modbusSel_r};
                    osl_pkg::ADDR_LIMIT: rdData <= {18'h0, limit_r};
                    // Life monitor is independent of any terminal assignment
                    osl_pkg::ADDR_LIFE: rdData <= {30'h0, fanDrop_r, capLife_r};
                    osl_pkg::ADDR_IRQ_STAT: rdData <= {28'h0, irqStat_r};
                    osl_pkg::ADDR_IRQ_MASK: rdData <= {28'h0, irqMask_r};
                    osl_pkg::ADDR_RESULT: rdData <= {26'h0, combRes};
                    default: ;
                endcase
            end
        end
    end

endmodule : osl_combiner

// [tb/osl_ext_equip.sv]
// Model of the external equipment wired to the output terminals and relay
`timescale 1ns/1ps
module osl_ext_equip (
    // Clock
    input wire logic clk,
    // Contacts driven by the drive
    input wire logic [4:0] termOut,
    input wire logic relayOut,
    // Levels latched by the equipment
    output logic [4:0] seenTerm,
    output logic seenRelay
);
    // Equipment samples its inputs once a clock, so it adds one cycle of lag
    always_ff @(posedge clk) begin
        seenTerm <= termOut;
        seenRelay <= relayOut;
    end
endmodule : osl_ext_equip

// [tb/osl_combiner_props.sv]
// Port-level checker of the combiner block
`timescale 1ns/1ps
module osl_combiner_props #(
    parameter int TICK_CYCLES = 10
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Register port
    input wire osl_pkg::osl_bus_req_t busReq,
    input wire logic [31:0] rdData,
    // Status and commands
    input wire logic [63:0] statusSig,
    input wire logic capLifeDue,
    input wire logic fanBelowLimit,
    input wire logic linkRxData,
    input wire logic fwdRunCmd,
    input wire logic revRunCmd,
    // Outputs
    input wire logic [4:0] termOut,
    input wire logic relayOut,
    input wire logic motorStop,
    input wire logic irq
);
    // --------------------------------------------------------
    // Sequences
    // --------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Flags settle within two cycles, so four steady cycles are a safe margin
    sequence s_life_rd;
        clkEn && busReq.rd && busReq.addr == osl_pkg::ADDR_LIFE;
    endsequence
    sequence s_cap_hi;
        (clkEn && capLifeDue) [*4];
    endsequence
    sequence s_cap_lo;
        (clkEn && !capLifeDue) [*4];
    endsequence
    sequence s_fan_lo;
        (clkEn && !fanBelowLimit) [*4];
    endsequence
    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    a_rd_idle: assert property (clkEn && !busReq.rd |=> rdData == 32'h0)
        else $error("read data not zero outside a read");
    a_life_cap: assert property (s_cap_hi ##0 s_life_rd |=> rdData[0])
        else $error("life monitor misses capacitor warning");
    a_life_nocap: assert property (s_cap_lo ##0 s_life_rd |=> !rdData[0])
        else $error("life monitor shows stray capacitor warning");
    a_life_nofan: assert property (s_fan_lo ##0 s_life_rd |=> !rdData[1])
        else $error("life monitor shows stray fan drop");
    a_stop_both: assert property (clkEn && fwdRunCmd && revRunCmd |=> motorStop)
        else $error("motor not stopped on both run commands");
    a_stop_none: assert property (clkEn && !(fwdRunCmd && revRunCmd) |=> !motorStop)
        else $error("motor stopped without both run commands");
    a_res_width: assert property (clkEn && busReq.rd && (busReq.addr == osl_pkg::ADDR_LIFE
        || busReq.addr == osl_pkg::ADDR_RESULT) |=> rdData[31:6] == 26'h0)
        else $error("result or monitor word wider than six bits");
    a_reset_low: assert property (disable iff (1'b0) !rst_n |=> termOut == 5'h0
        && !relayOut && !motorStop && !irq)
        else $error("outputs not low after reset");
endmodule : osl_combiner_props

bind osl_combiner osl_combiner_props #(.TICK_CYCLES(TICK_CYCLES)) i_osl_combiner_props (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .busReq(busReq), .rdData(rdData),
    .statusSig(statusSig), .capLifeDue(capLifeDue), .fanBelowLimit(fanBelowLimit),
    .linkRxData(linkRxData), .fwdRunCmd(fwdRunCmd), .revRunCmd(revRunCmd),
    .termOut(termOut), .relayOut(relayOut), .motorStop(motorStop), .irq(irq));

// [tb/osl_combiner_tb.sv]
// Self-checking bench of the output signal logic combiner
`timescale 1ns/1ps
module osl_combiner_tb;
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    localparam int TICKS = 10;  // Short tick keeps timeouts to tens of cycles
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    osl_pkg::osl_bus_req_t busReq = '0;
    logic [63:0] statusSig = 64'h0;
    logic capLifeDue = 1'b0, fanBelowLimit = 1'b0, linkRxData = 1'b0;
    logic fwdRunCmd = 1'b0, revRunCmd = 1'b0, rdPend = 1'b0;
    logic [31:0] rdData;
    logic [4:0] termOut, seenTerm;
    logic relayOut, motorStop, irq, seenRelay;
    logic [15:0] lfsr = 16'h7036;
    logic [5:0] ca[6], cb[6];
    logic [1:0] co[6];
    logic [31:0] expQ[$];
    string nameQ[$];
    int fails = 0;
    int nTests = 0;

    osl_combiner #(.TICK_CYCLES(TICKS)) i_osl_combiner (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .busReq(busReq), .rdData(rdData), .statusSig(statusSig),
        .capLifeDue(capLifeDue), .fanBelowLimit(fanBelowLimit), .linkRxData(linkRxData),
        .fwdRunCmd(fwdRunCmd), .revRunCmd(revRunCmd), .termOut(termOut),
        .relayOut(relayOut), .motorStop(motorStop), .irq(irq));
    osl_ext_equip i_osl_ext_equip (.clk(clk), .termOut(termOut), .relayOut(relayOut),
        .seenTerm(seenTerm), .seenRelay(seenRelay));

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    // Result codes and codes above 31 read as zero in this stimulus
    function automatic logic model_res(input int k, input logic [31:0] s);
        logic x, y;
        x = (ca[k] > 6'h1f) ? 1'b0 : s[ca[k][4:0]];
        y = s[cb[k][4:0]];
        case (co[k])
            2'h1: model_res = x | y;
            2'h2: model_res = x ^ y;
            default: model_res = x & y;
        endcase
    endfunction : model_res
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("Checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // Strobe drops one edge later, so back-to-back calls never reassign it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        expQ.push_back(e);
        nameQ.push_back(n);
        @(posedge clk);
        busReq.rd <= 1'b0;
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Clock, watchdog and read-data monitor
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
    always @(posedge clk) rdPend <= busReq.rd && clkEn && rst_n;
    // Read data stand only in the cycle after the strobe; sample mid-cycle
    always @(negedge clk) begin
        if (rdPend && expQ.size() > 0) begin
            check(nameQ.pop_front(), rdData, expQ.pop_front());
        end
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        logic [31:0] s, w;
        int t;
        for (int k = 0; k < 6; k++) begin
            ca[k] = 6'h0;
            cb[k] = 6'h0;
            co[k] = 2'h0;
        end
        idle(3);
        rst_n <= 1'b1;
        rd("term0", osl_pkg::ADDR_TERM_BASE, 32'h3f);
        rd("relay", osl_pkg::ADDR_RELAY, 32'h3f);
        rd("life", osl_pkg::ADDR_LIFE, 32'h0);
        wr(8'h20, 32'hffff_ffff);
        rd("unmapped", 8'h20, 32'h0);
        // Every combiner, every operator, results routed to terminals and relay
        for (int k = 0; k < 6; k++) begin
            for (int op = 0; op < 4; op++) begin
                lfsr = lfsr_next(lfsr);
                ca[k] = (op == 3) ? 6'h21 + 6'(k) : {1'b0, lfsr[4:0]};
                cb[k] = {1'b0, lfsr[9:5]};
                if (ca[k] == 6'h0b) ca[k] = 6'h0a;
                if (cb[k] == 6'h0b) cb[k] = 6'h0c;
                co[k] = (op == 3) ? 2'h1 : 2'(op);
                wr(osl_pkg::ADDR_COMB_BASE + 8'(k), {14'h0, co[k], 2'h0, cb[k], 2'h0, ca[k]});
                wr((k == 5) ? osl_pkg::ADDR_RELAY : osl_pkg::ADDR_TERM_BASE + 8'(k % 5),
                   32'h21 + 32'(k));
                for (int j = 0; j < 2; j++) begin
                    lfsr = lfsr_next(lfsr);
                    s = {lfsr, lfsr_next(lfsr)};
                    statusSig <= {32'h0, s};
                    idle(5);
                    w = 32'h0;
                    for (int m = 0; m < 6; m++) w[m] = model_res(m, s);
                    t = (k == 5) ? 5 : k % 5;
                    check("routed", {31'h0, (k == 5) ? seenRelay : seenTerm[t]}, w[k]);
                    rd("results", osl_pkg::ADDR_RESULT, w);
                end
            end
        end
        // Operator code 3 is not an operator, so its combiner must stay low
        statusSig <= 64'h1;
        wr(osl_pkg::ADDR_COMB_BASE, 32'h3_0000);
        w = 32'h0;
        for (int m = 1; m < 6; m++) w[m] = model_res(m, 32'h1);
        rd("op three", osl_pkg::ADDR_RESULT, w);
        // Starting contact on terminal and relay, both commands stop the motor
        wr(osl_pkg::ADDR_TERM_BASE, 32'h0b);
        wr(osl_pkg::ADDR_RELAY, 32'h29);
        for (int v = 1; v < 5; v++) begin
            fwdRunCmd <= v[0];
            revRunCmd <= v[1];
            idle(5);
            check("start term", {31'h0, seenTerm[0]}, {31'h0, v[0] | v[1]});
            check("start relay", {31'h0, seenRelay}, {31'h0, v[0] | v[1]});
            check("stop", {31'h0, motorStop}, {31'h0, v[0] & v[1]});
        end
        // Capacitor warning and fan drop, fan mode 01 suppresses the latter
        wr(osl_pkg::ADDR_TERM_BASE + 8'h1, 32'h27);
        wr(osl_pkg::ADDR_TERM_BASE + 8'h2, 32'h28);
        capLifeDue <= 1'b1;
        fanBelowLimit <= 1'b1;
        idle(5);
        check("warn terms", {30'h0, seenTerm[2:1]}, 32'h3);
        rd("life", osl_pkg::ADDR_LIFE, 32'h3);
        wr(osl_pkg::ADDR_CTRL, 32'h2);
        idle(5);
        check("fan quiet", {31'h0, seenTerm[2]}, 32'h0);
        rd("life quiet", osl_pkg::ADDR_LIFE, 32'h1);
        wr(osl_pkg::ADDR_CTRL, 32'h0);
        idle(5);
        check("fan term", {31'h0, seenTerm[2]}, 32'h1);
        // Sticky status, mask, clear by writing ones
        rd("irq stat", osl_pkg::ADDR_IRQ_STAT, 32'hb);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(osl_pkg::ADDR_IRQ_MASK, 32'h8);
        idle(3);
        check("irq on", {31'h0, irq}, 32'h1);
        wr(osl_pkg::ADDR_IRQ_STAT, 32'hb);
        fanBelowLimit <= 1'b0;
        idle(3);
        fanBelowLimit <= 1'b1;
        idle(5);
        check("irq off", {31'h0, irq}, 32'h0);
        rd("irq fan", osl_pkg::ADDR_IRQ_STAT, 32'h2);
        // Link timeout held until the next datum, only under Modbus
        wr(osl_pkg::ADDR_LIMIT, 32'hffff);
        rd("limit sat", osl_pkg::ADDR_LIMIT, {18'h0, osl_pkg::LIMIT_MAX});
        wr(osl_pkg::ADDR_LIMIT, 32'h3);
        wr(osl_pkg::ADDR_TERM_BASE + 8'h3, 32'h20);
        wr(osl_pkg::ADDR_CTRL, 32'h1);
        linkRxData <= 1'b1;
        idle(1);
        linkRxData <= 1'b0;
        // Three steps of ten cycles: the flag must show about 32 cycles after the datum
        idle(26);
        check("link early", {31'h0, seenTerm[3]}, 32'h0);
        t = 0;
        while (seenTerm[3] !== 1'b1 && t < 12) begin
            idle(1);
            t++;
        end
        if (t == 12) begin
            fails++;
            close_out();
        end
        idle(40);
        check("link held", {31'h0, seenTerm[3]}, 32'h1);
        linkRxData <= 1'b1;
        idle(1);
        linkRxData <= 1'b0;
        idle(4);
        check("link clear", {31'h0, seenTerm[3]}, 32'h0);
        wr(osl_pkg::ADDR_CTRL, 32'h0);
        idle(80);
        check("link off", {31'h0, seenTerm[3]}, 32'h0);
        // Frozen while the clock enable is low
        clkEn <= 1'b0;
        wr(osl_pkg::ADDR_TERM_BASE + 8'h4, 32'h05);
        clkEn <= 1'b1;
        rd("frozen", osl_pkg::ADDR_TERM_BASE + 8'h4, 32'h25);
        idle(3);
        close_out();
    end
endmodule : osl_combiner_tb
